// *** hw/emm_mailbox.sv ***
// command mailbox, monitor sequencer and break control for the emulator
`timescale 1ns/1ps
`default_nettype none


module emm_mailbox (
    input  wire logic                         clk_i,
    input  wire logic                         resetn_i,
    // host access to shared emulation memory
    input  wire logic                         host_we_i,     // write one word
    input  wire logic                         host_re_i,     // read one word
    input  wire logic [emm_pkg::SEL_W-1:0]    host_sel_i,    // word select
    input  wire logic [emm_pkg::DATA_W-1:0]   host_wdata_i,  // write data
    output logic      [emm_pkg::DATA_W-1:0]   host_rdata_o,  // read data
    output logic      [emm_pkg::DATA_W-1:0]   mailbox_o,     // live command word
    // host direct control
    input  wire logic                         host_reset_i,  // hold processor reset
    input  wire logic                         host_halt_i,   // stop bus activity
    input  wire logic                         break_cmd_i,   // explicit break
    input  wire logic                         rom_brk_en_i,  // break on rom writes
    input  wire logic                         step_load_i,   // arm step compare
    input  wire logic [emm_pkg::ADDR_W-1:0]   step_pc_i,     // next pc to break on
    input  wire logic                         map_we_i,      // mapper entry write
    input  wire logic [emm_pkg::MAP_IW-1:0]   map_idx_i,     // mapper block
    input  wire emm_pkg::emm_map_t            map_data_i,    // mapper class
    // emulation processor side
    input  wire emm_pkg::emm_bus_t            emu_bus_i,     // processor bus cycle
    input  wire logic                         trigger_i,     // analyzer trigger
    output logic                              emu_reset_o,   // processor reset
    output logic                              emu_halt_o,    // processor bus stop
    output logic                              in_monitor_o,  // monitor is running
    output logic                              run_o,         // pulse: jump to run_pc_o
    output logic      [emm_pkg::ADDR_W-1:0]   run_pc_o,      // exit program counter
    output logic      [emm_pkg::CAUSE_W-1:0]  cause_o,       // last break cause
    // target memory write port
    output logic                              tgt_we_o,      // target write strobe
    output logic      [emm_pkg::ADDR_W-1:0]   tgt_addr_o,    // target byte address
    output logic      [emm_pkg::DATA_W-1:0]   tgt_wdata_o    // target write data
);

    // ------------------------------------------------------------
    // state and storage
    // ------------------------------------------------------------
    emm_pkg::emm_state_t                state_q;          // sequencer state
    emm_pkg::emm_class_t                cls;              // classified cycle
    logic [emm_pkg::DATA_W-1:0]         buf_q [emm_pkg::BUF_N]; // transfer_buffer
    logic [emm_pkg::DATA_W-1:0]         count_q;          // words to load
    logic [emm_pkg::ADDR_W-1:0]         dst_q;            // target load address
    logic [emm_pkg::ADDR_W-1:0]         pc_q;             // saved program counter
    logic [emm_pkg::BUF_IW-1:0]         idx_q;            // load word index
    logic [emm_pkg::ADDR_W-1:0]         step_q;           // step compare address
    logic                               step_arm_q;       // step compare armed
    logic [emm_pkg::CAUSE_W-1:0]        brk;              // break sources now
    logic                               brk_any;          // any source fires
    logic                               cmd_done;         // clear pending flag
    logic                               host_mb_wr;       // host writes mailbox
    logic                               last_word;        // final load word
    logic [7:0]                         cmd;              // command number

    assign host_mb_wr = host_we_i && (host_sel_i == emm_pkg::SEL_MAILBOX);
    assign cmd        = mailbox_o[emm_pkg::CMD_HI:0];
    assign last_word  = (count_q <= emm_pkg::DATA_W'(idx_q) + 16'h0001) ||
                        (idx_q == emm_pkg::BUF_IW'(emm_pkg::BUF_N - 1));

    // ------------------------------------------------------------
    // address mapper
    // ------------------------------------------------------------
    emm_mapper u_mapper (
        .clk_i      (clk_i),
        .resetn_i   (resetn_i),
        .map_we_i   (map_we_i),
        .map_idx_i  (map_idx_i),
        .map_data_i (map_data_i),
        .bus_i      (emu_bus_i),
        .class_o    (cls)
    );

    // ------------------------------------------------------------
    // break sources, only watched while a user program runs
    // ------------------------------------------------------------
    always_comb begin
        brk = '0;
        brk[emm_pkg::CAUSE_TRIG]  = trigger_i;
        brk[emm_pkg::CAUSE_GUARD] = cls.bus.valid &&
                                    (cls.cls.space == emm_pkg::SPACE_GUARD);
        brk[emm_pkg::CAUSE_ROMWR] = cls.bus.valid && cls.bus.write &&
                                    cls.cls.rom && rom_brk_en_i;
        brk[emm_pkg::CAUSE_CMD]   = break_cmd_i;
        brk[emm_pkg::CAUSE_STEP]  = step_arm_q && emu_bus_i.valid &&
                                    (emu_bus_i.addr == step_q);
        brk_any = (state_q == emm_pkg::ST_USER) && !emu_reset_o && (brk != '0);
    end

    // completion: presence and exit finish at once, load at its last word
    always_comb begin
        cmd_done = 1'b0;
        if (state_q == emm_pkg::ST_IDLE && mailbox_o[emm_pkg::PEND_BIT]) begin
            cmd_done = (cmd == emm_pkg::CMD_PRESENT) || (cmd == emm_pkg::CMD_EXIT);
        end else if (state_q == emm_pkg::ST_LOAD) begin
            cmd_done = last_word;
        end
    end

    // ------------------------------------------------------------
    // sequencer
    // ------------------------------------------------------------
    always_ff @(posedge clk_i) begin
        if (!resetn_i || emu_reset_o) begin
            state_q <= emm_pkg::ST_USER;
        end else begin
            unique case (state_q)
                emm_pkg::ST_USER: begin
                    if (brk_any) begin
                        state_q <= emm_pkg::ST_IDLE;
                    end
                end
                emm_pkg::ST_IDLE: begin
                    // invalid numbers are left pending so the host times out
                    if (mailbox_o[emm_pkg::PEND_BIT] && cmd == emm_pkg::CMD_EXIT) begin
                        state_q <= emm_pkg::ST_USER;
                    end else if (mailbox_o[emm_pkg::PEND_BIT] &&
                                 cmd == emm_pkg::CMD_LOAD) begin
                        state_q <= (count_q == '0) ? emm_pkg::ST_IDLE : emm_pkg::ST_LOAD;
                    end
                end
                emm_pkg::ST_LOAD: begin
                    if (last_word) begin
                        state_q <= emm_pkg::ST_IDLE;
                    end
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // mailbox word: a host post wins over a same-cycle completion
    // ------------------------------------------------------------
    always_ff @(posedge clk_i) begin
        if (!resetn_i) begin
            mailbox_o <= '0;
        end else if (host_mb_wr) begin
            mailbox_o <= host_wdata_i;
        end else if (cmd_done || (state_q == emm_pkg::ST_IDLE &&
                     cmd == emm_pkg::CMD_LOAD && count_q == '0)) begin
            mailbox_o[emm_pkg::PEND_BIT] <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // load parameters and transfer buffer, written by the host
    // ------------------------------------------------------------
    always_ff @(posedge clk_i) begin
        if (!resetn_i) begin
            count_q <= '0;
            dst_q   <= '0;
        end else if (host_we_i) begin
            if (host_sel_i == emm_pkg::SEL_COUNT) begin
                count_q <= host_wdata_i;
            end
            if (host_sel_i == emm_pkg::SEL_DST_LO) begin
                dst_q[emm_pkg::DATA_W-1:0] <= host_wdata_i;
            end
            if (host_sel_i == emm_pkg::SEL_DST_HI) begin
                dst_q[emm_pkg::ADDR_W-1:emm_pkg::DATA_W] <= host_wdata_i[7:0];
            end
        end
    end

    for (genvar g = 0; g < emm_pkg::BUF_N; g++) begin : g_buf
        always_ff @(posedge clk_i) begin
            if (!resetn_i) begin
                buf_q[g] <= '0;
            end else if (host_we_i && host_sel_i[emm_pkg::SEL_BUF_BIT] &&
                         host_sel_i[emm_pkg::BUF_IW-1:0] == emm_pkg::BUF_IW'(g)) begin
                buf_q[g] <= host_wdata_i;
            end
        end
    end

    // ------------------------------------------------------------
    // saved program counter: break captures it, host may replace it
    // ------------------------------------------------------------
    always_ff @(posedge clk_i) begin
        if (!resetn_i) begin
            pc_q <= '0;
        end else if (host_we_i && host_sel_i == emm_pkg::SEL_PC_LO) begin
            pc_q[emm_pkg::DATA_W-1:0] <= host_wdata_i;
        end else if (host_we_i && host_sel_i == emm_pkg::SEL_PC_HI) begin
            pc_q[emm_pkg::ADDR_W-1:emm_pkg::DATA_W] <= host_wdata_i[7:0];
        end else if (brk_any) begin
            pc_q <= emu_bus_i.addr;
        end
    end

    // ------------------------------------------------------------
    // exit: jump to the saved program counter
    // ------------------------------------------------------------
    always_ff @(posedge clk_i) begin
        if (!resetn_i) begin
            run_o    <= 1'b0;
            run_pc_o <= '0;
        end else begin
            run_o <= (state_q == emm_pkg::ST_IDLE) && mailbox_o[emm_pkg::PEND_BIT] &&
                     (cmd == emm_pkg::CMD_EXIT) && !emu_reset_o;
            if (state_q == emm_pkg::ST_IDLE && cmd == emm_pkg::CMD_EXIT) begin
                run_pc_o <= pc_q;
            end
        end
    end

    // ------------------------------------------------------------
    // target writes, one buffer word per cycle
    // ------------------------------------------------------------
    always_ff @(posedge clk_i) begin
        if (!resetn_i) begin
            idx_q       <= '0;
            tgt_we_o    <= 1'b0;
            tgt_addr_o  <= '0;
            tgt_wdata_o <= '0;
        end else begin
            tgt_we_o <= (state_q == emm_pkg::ST_LOAD);
            if (state_q == emm_pkg::ST_LOAD) begin
                tgt_addr_o  <= dst_q + {20'h00000, idx_q, 1'b0};
                tgt_wdata_o <= buf_q[idx_q];
                idx_q       <= last_word ? '0 : idx_q + 3'h1;
            end else begin
                idx_q <= '0;
            end
        end
    end

    // ------------------------------------------------------------
    // step compare and break cause
    // ------------------------------------------------------------
    always_ff @(posedge clk_i) begin
        if (!resetn_i) begin
            step_arm_q <= 1'b0;
            step_q     <= '0;
            cause_o    <= '0;
        end else begin
            if (step_load_i) begin
                step_arm_q <= 1'b1;
                step_q     <= step_pc_i;
            end else if (brk_any && brk[emm_pkg::CAUSE_STEP]) begin
                step_arm_q <= 1'b0;
            end
            if (brk_any) begin
                cause_o <= brk;
            end
        end
    end

    // ------------------------------------------------------------
    // host direct control and read back
    // ------------------------------------------------------------
    always_ff @(posedge clk_i) begin
        if (!resetn_i) begin
            emu_reset_o  <= 1'b1;
            emu_halt_o   <= 1'b0;
            in_monitor_o <= 1'b0;
            host_rdata_o <= '0;
        end else begin
            emu_reset_o  <= host_reset_i;
            emu_halt_o   <= host_halt_i;
            in_monitor_o <= (state_q != emm_pkg::ST_USER) && !emu_reset_o &&
                            !(state_q == emm_pkg::ST_IDLE && cmd == emm_pkg::CMD_EXIT &&
                              mailbox_o[emm_pkg::PEND_BIT]);
            if (host_re_i) begin
                if (host_sel_i[emm_pkg::SEL_BUF_BIT]) begin
                    host_rdata_o <= buf_q[host_sel_i[emm_pkg::BUF_IW-1:0]];
                end else begin
                    unique case (host_sel_i)
                        emm_pkg::SEL_MAILBOX: host_rdata_o <= mailbox_o;
                        emm_pkg::SEL_COUNT:   host_rdata_o <= count_q;
                        emm_pkg::SEL_DST_LO:  host_rdata_o <= dst_q[15:0];
                        emm_pkg::SEL_DST_HI:  host_rdata_o <= {8'h00, dst_q[23:16]};
                        emm_pkg::SEL_PC_LO:   host_rdata_o <= pc_q[15:0];
                        emm_pkg::SEL_PC_HI:   host_rdata_o <= {8'h00, pc_q[23:16]};
                        emm_pkg::SEL_CAUSE:   host_rdata_o <= {11'h000, cause_o};
                        default:              host_rdata_o <= '0;
                    endcase
                end
            end
        end
    end

endmodule

`default_nettype wire

// *** hw/emm_mapper.sv ***
// programmable address mapper that classifies every processor bus cycle
`timescale 1ns/1ps
`default_nettype none

module emm_mapper (
    input  wire logic                         clk_i,
    input  wire logic                         resetn_i,
    input  wire logic                         map_we_i,     // write one block entry
    input  wire logic [emm_pkg::MAP_IW-1:0]   map_idx_i,    // block to write
    input  wire emm_pkg::emm_map_t            map_data_i,   // new class of block
    input  wire emm_pkg::emm_bus_t            bus_i,        // live processor cycle
    output var  emm_pkg::emm_class_t          class_o       // cycle with its class
);

    // ------------------------------------------------------------
    // block table, one entry per address block
    // ------------------------------------------------------------
    emm_pkg::emm_map_t table_q [emm_pkg::MAP_N];   // class per block

    // each entry is loaded only when its own index is written
    for (genvar g = 0; g < emm_pkg::MAP_N; g++) begin : g_entry
        always_ff @(posedge clk_i) begin
            if (!resetn_i) begin
                table_q[g] <= emm_pkg::MAP_RESET;
            end else if (map_we_i && (map_idx_i == emm_pkg::MAP_IW'(g))) begin
                table_q[g] <= map_data_i;
            end
        end
    end

    // ------------------------------------------------------------
    // classification, one cycle behind the bus
    // ------------------------------------------------------------
    always_ff @(posedge clk_i) begin
        if (!resetn_i) begin
            class_o <= '0;
        end else begin
            class_o.bus <= bus_i;
            class_o.cls <= table_q[bus_i.addr[emm_pkg::ADDR_W-1:emm_pkg::MAP_LSB]];
        end
    end

endmodule

`default_nettype wire

// *** inc/emm_pkg.sv ***
// shared constants and types for the emulation monitor mailbox
package emm_pkg;

    // ------------------------------------------------------------
    // widths
    // ------------------------------------------------------------
    localparam int unsigned DATA_W   = 16;         // mailbox and memory word width
    localparam int unsigned ADDR_W   = 24;         // emulation processor address width
    localparam int unsigned SEL_W    = 4;          // host word select width
    localparam int unsigned BUF_N    = 8;          // transfer buffer depth in words
    localparam int unsigned BUF_IW   = 3;          // transfer buffer index width
    localparam int unsigned MAP_N    = 16;         // mapper blocks
    localparam int unsigned MAP_IW   = 4;          // mapper block index width
    localparam int unsigned MAP_LSB  = 20;         // lowest address bit of block index

    // ------------------------------------------------------------
    // mailbox word layout
    // ------------------------------------------------------------
    localparam int unsigned PEND_BIT = 15;         // pending command flag
    localparam int unsigned CMD_HI   = 7;          // command number top bit

    // ------------------------------------------------------------
    // host word selects into shared emulation memory
    // ------------------------------------------------------------
    localparam logic [3:0] SEL_MAILBOX = 4'h0;     // command word
    localparam logic [3:0] SEL_COUNT   = 4'h1;     // word count for target load
    localparam logic [3:0] SEL_DST_LO  = 4'h2;     // target address low word
    localparam logic [3:0] SEL_DST_HI  = 4'h3;     // target address high byte
    localparam logic [3:0] SEL_PC_LO   = 4'h4;     // saved program counter low word
    localparam logic [3:0] SEL_PC_HI   = 4'h5;     // saved program counter high byte
    localparam logic [3:0] SEL_CAUSE   = 4'h6;     // break cause, read only
    localparam int unsigned SEL_BUF_BIT = 3;       // set: transfer buffer word

    // ------------------------------------------------------------
    // command numbers
    // ------------------------------------------------------------
    localparam logic [7:0] CMD_PRESENT = 8'h00;    // presence query
    localparam logic [7:0] CMD_EXIT    = 8'h01;    // reload registers and run
    localparam logic [7:0] CMD_LOAD    = 8'h02;    // copy transfer buffer to target

    // ------------------------------------------------------------
    // mapper classes
    // ------------------------------------------------------------
    localparam logic [1:0] SPACE_EMUL  = 2'h0;     // emulation memory
    localparam logic [1:0] SPACE_TGT   = 2'h1;     // target memory
    localparam logic [1:0] SPACE_GUARD = 2'h2;     // guarded, any access breaks
    localparam logic [2:0] MAP_RESET   = 3'h0;     // emulation ram after reset

    // ------------------------------------------------------------
    // break cause bits
    // ------------------------------------------------------------
    localparam int unsigned CAUSE_TRIG  = 0;       // analyzer trigger
    localparam int unsigned CAUSE_GUARD = 1;       // guarded access
    localparam int unsigned CAUSE_ROMWR = 2;       // write to rom
    localparam int unsigned CAUSE_CMD   = 3;       // explicit break
    localparam int unsigned CAUSE_STEP  = 4;       // single step hit
    localparam int unsigned CAUSE_W     = 5;

    // ------------------------------------------------------------
    // types
    // ------------------------------------------------------------
    typedef struct packed {
        logic [1:0] space;                         // emulation, target or guarded
        logic       rom;                           // set: read only block
    } emm_map_t;

    typedef struct packed {
        logic              valid;                  // a bus cycle is present
        logic              write;                  // cycle is a write
        logic [ADDR_W-1:0] addr;                   // cycle address
    } emm_bus_t;

    typedef struct packed {
        emm_bus_t bus;                             // the classified cycle
        emm_map_t cls;                             // its class
    } emm_class_t;

    typedef enum logic [1:0] {
        ST_USER,                                   // user program runs
        ST_IDLE,                                   // monitor polls the mailbox
        ST_LOAD                                    // monitor writes target memory
    } emm_state_t;

endpackage

// *** verification/emm_host_model.sv ***
// host model that writes shared words and posts mailbox commands
`timescale 1ns/1ps
`default_nettype none
module emm_host_model (
    input  wire logic        clk_i,
    input  wire logic [15:0] mailbox_i,
    input  wire logic [15:0] rdata_i,
    output logic             re_o,
    output logic             we_o,
    output logic [3:0]       sel_o,
    output logic [15:0]      wdata_o
);
    initial we_o = 1'b0;
    initial re_o = 1'b0;
    initial sel_o = 4'h7;
    initial wdata_o = 16'h0000;
    // one word write; data shows the inverse once released
    task automatic wr(input logic [3:0] s, input logic [15:0] d);
        @(posedge clk_i) #1;
        {we_o, sel_o, wdata_o} = {1'b1, s, d};
        @(posedge clk_i) #1;
        {we_o, wdata_o} = {1'b0, ~d};
    endtask
    // one word read; data is taken once it stands after the edge
    task automatic rd(input logic [3:0] s, output logic [15:0] d);
        @(posedge clk_i) #1;
        {re_o, sel_o} = {1'b1, s};
        @(posedge clk_i) #1;
        re_o = 1'b0;
        d = rdata_i;
    endtask
    // post a command, then poll the pending flag for a set span
    task automatic post(input logic [7:0] c, input int tmo, output logic ok);
        wr(4'h0, {8'h80, c});
        ok = 1'b0;
        repeat (tmo) begin
            @(posedge clk_i) #1;
            if (mailbox_i[15] === 1'b0) ok = 1'b1;
        end
    endtask
endmodule
`default_nettype wire

// *** verification/emm_mailbox_sva.sv ***
// port checker for the mailbox block
`timescale 1ns/1ps
`default_nettype none
module emm_mailbox_sva (
    input wire logic        clk_i,
    input wire logic        resetn_i,
    input wire logic        host_we_i,
    input wire logic        host_reset_i,
    input wire logic        trigger_i,
    input wire logic [15:0] mailbox_o,
    input wire logic        emu_reset_o,
    input wire logic        in_monitor_o,
    input wire logic        run_o,
    input wire logic        tgt_we_o,
    input wire logic [23:0] tgt_addr_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (!resetn_i);
    rst_follow_a: assert property ($past(resetn_i) |-> emu_reset_o == $past(host_reset_i))
        else $error("processor reset not following host");
    trig_break_a: assert property (trigger_i && !in_monitor_o && !emu_reset_o && !host_reset_i
        && !mailbox_o[15] |-> ##[1:2] in_monitor_o) else $error("trigger did not break");
    pres_clear_a: assert property (in_monitor_o && !emu_reset_o && !$past(emu_reset_o)
        && !host_we_i && mailbox_o == 16'h8000 |=> !mailbox_o[15]) else $error("query not done");
    bad_cmd_a: assert property (mailbox_o[15] && mailbox_o[7:0] > 8'h02 && !host_we_i
        |=> $stable(mailbox_o)) else $error("invalid command touched");
    exit_run_a: assert property (in_monitor_o && !emu_reset_o && !$past(emu_reset_o)
        && !host_we_i && mailbox_o == 16'h8001 |-> ##[1:2] run_o) else $error("exit without run");
    run_pulse_a: assert property (run_o |=> !run_o)
        else $error("run strobe too long");
    rst_user_a: assert property (emu_reset_o ##1 emu_reset_o |=> !in_monitor_o)
        else $error("monitor while held in reset");
    load_step_a: assert property (tgt_we_o && $past(tgt_we_o)
        |-> tgt_addr_o == $past(tgt_addr_o) + 24'h000002) else $error("target address step");
endmodule
bind emm_mailbox emm_mailbox_sva sva (.clk_i(clk_i), .resetn_i(resetn_i),
    .host_we_i(host_we_i), .host_reset_i(host_reset_i), .trigger_i(trigger_i),
    .mailbox_o(mailbox_o), .emu_reset_o(emu_reset_o), .in_monitor_o(in_monitor_o),
    .run_o(run_o), .tgt_we_o(tgt_we_o), .tgt_addr_o(tgt_addr_o));
`default_nettype wire

// *** verification/tb_top.sv ***
// self-checking bench for the mailbox block
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    logic clk_i = 1'b0, resetn_i = 1'b0, host_re_i, host_reset_i = 1'b0, ok;
    logic host_halt_i = 1'b0, break_cmd_i = 1'b0, trigger_i = 1'b0, step_load_i = 1'b0;
    logic rom_brk_en_i = 1'b1, map_we_i = 1'b0, host_we_i, run_o, tgt_we_o, emu_reset_o;
    logic emu_halt_o, in_monitor_o;
    logic [3:0]  host_sel_i, map_idx_i = 4'h0;
    logic [15:0] host_wdata_i, host_rdata_o, mailbox_o, tgt_wdata_o, rd_data;
    logic [23:0] step_pc_i = 24'h000400, run_pc_o, tgt_addr_o;
    logic [4:0]  cause_o;
    logic [39:0] tq[$];
    emm_pkg::emm_map_t map_data_i = '0;
    emm_pkg::emm_bus_t emu_bus_i = '0;
    int n_errors = 0, compares = 0;
    emm_mailbox dut (.clk_i(clk_i), .resetn_i(resetn_i), .host_we_i(host_we_i),
        .host_re_i(host_re_i), .host_sel_i(host_sel_i), .host_wdata_i(host_wdata_i),
        .host_rdata_o(host_rdata_o), .mailbox_o(mailbox_o), .host_reset_i(host_reset_i),
        .host_halt_i(host_halt_i), .break_cmd_i(break_cmd_i), .rom_brk_en_i(rom_brk_en_i),
        .step_load_i(step_load_i), .step_pc_i(step_pc_i), .map_we_i(map_we_i),
        .map_idx_i(map_idx_i), .map_data_i(map_data_i), .emu_bus_i(emu_bus_i),
        .trigger_i(trigger_i), .emu_reset_o(emu_reset_o), .emu_halt_o(emu_halt_o),
        .in_monitor_o(in_monitor_o), .run_o(run_o), .run_pc_o(run_pc_o), .cause_o(cause_o),
        .tgt_we_o(tgt_we_o), .tgt_addr_o(tgt_addr_o), .tgt_wdata_o(tgt_wdata_o));
    emm_host_model host (.clk_i(clk_i), .mailbox_i(mailbox_o), .rdata_i(host_rdata_o),
        .re_o(host_re_i), .we_o(host_we_i), .sel_o(host_sel_i), .wdata_o(host_wdata_i));
    initial forever #50 clk_i = ~clk_i;
    always @(posedge clk_i) if (tgt_we_o === 1'b1) tq.push_back({tgt_addr_o, tgt_wdata_o});
    task automatic chk(input string nm, input logic [39:0] got, exp);
        compares++;
        if (got !== exp) begin
            n_errors++;
            $display("wrong value %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge clk_i);
        #1;
    endtask
    task automatic stop_test;
        $display("errors %0d compares %0d", n_errors, compares);
        if (n_errors == 0 && compares > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    // direct control lines, then a query that must time out in user code
    task automatic t_ctrl;
        {host_reset_i, host_halt_i} = 2'b11;
        tick(2);
        chk("hold", {emu_reset_o, emu_halt_o}, 2'b11);
        {host_reset_i, host_halt_i} = 2'b00;
        tick(2);
        host.post(8'h00, 6, ok);
        chk("absent", ok, 0);
        host.rd(4'h0, rd_data);
        chk("poll", rd_data, 16'h8000);
        host.wr(4'h0, 16'h0000);
        // absent monitor: break in, confirm presence, then leave again
        break_cmd_i = 1'b1;
        tick(1);
        break_cmd_i = 1'b0;
        tick(3);
        host.post(8'h00, 4, ok);
        chk("rescued", ok, 1);
        host.post(8'h01, 4, ok);
        chk("left", {ok, in_monitor_o}, 2'b10);
    endtask
    // each break source, monitor commands, a target load and an exit
    task automatic t_breaks;
        {map_we_i, map_idx_i, map_data_i} = {5'h11, emm_pkg::SPACE_GUARD, 1'b0};
        tick(1);
        {step_load_i, map_idx_i, map_data_i} = {5'h12, emm_pkg::SPACE_EMUL, 1'b1};
        tick(1);
        {step_load_i, map_we_i} = 2'b00;
        for (int i = 0; i < 5; i++) begin
            {trigger_i, break_cmd_i} = {i == 0, i == 3};
            emu_bus_i = '{i inside {1, 2, 4}, i == 2, (i == 4) ? 24'h000400 : 24'(i) << 20};
            tick(1);
            {trigger_i, break_cmd_i, emu_bus_i} = '0;
            tick(3);
            chk("cause", cause_o, 5'h01 << i);
            chk("monitor", in_monitor_o, 1);
            host.post(8'h00, 4, ok);
            chk("present", ok, 1);
            host.post(8'h07, 4, ok);
            chk("refused", ok, 0);
            host.wr(4'h1, 16'h0002);
            host.wr(4'h2, 16'h1000);
            host.wr(4'h3, 16'h0012);
            host.wr(4'h8, 16'hA5A5);
            host.wr(4'h9, 16'h5A5A);
            host.post(8'h02, 6, ok);
            chk("loaded", ok, 1);
            chk("word0", tq.pop_front(), 40'h121000A5A5);
            chk("word1", tq.pop_front(), 40'h1210025A5A);
            host.wr(4'h4, 16'h2000);
            host.wr(4'h5, 16'(i));
            host.post(8'h01, 4, ok);
            chk("exit", {ok, in_monitor_o, run_pc_o}, {2'b10, 8'(i), 16'h2000});
        end
    endtask
    initial begin
        tick(3);
        resetn_i = 1'b1;
        t_ctrl;
        t_breaks;
        stop_test;
    end
    initial begin
        #100000;
        n_errors++;
        stop_test;
    end
endmodule
`default_nettype wire
